/* File: verilog/led_fade_defs.svh */
`ifndef LED_FADE_DEFS_SVH
`define LED_FADE_DEFS_SVH
`define CLK_PERIOD_NS 4
`define CLK_HZ 250000000
`define PWM_HZ 220
`define PWM_SLOTS 256
`define PWM_SLOT_CYCLES (`CLK_HZ / (`PWM_HZ * `PWM_SLOTS))
`define DEBOUNCE_TIME_NS 1000000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FADE_STEP_TIME_NS 16000000
`define FADE_STEP_CYCLES (`FADE_STEP_TIME_NS / `CLK_PERIOD_NS)
`define FADE_STEPS 6'd63
`define GAMMA_MUL 18'h00042
`define GAMMA_SHIFT 10
`define ADDR_STATUS 3'h0
`define ADDR_MASK 3'h1
`define ADDR_FADE_UP 3'h2
`define ADDR_FADE_DN 3'h3
`define ADDR_STATE 3'h4
`define EV_DONE_A 0
`define EV_DONE_B 1
`define EV_FAULT 2
`define EV_W 3
`define IVL_W 24
`define MASK_RESET 3'h0
`endif

/* File: verilog/led_fade_pkg.sv */
package led_fade_pkg;
  typedef enum logic [2:0] {
    FADE_IDLE = 3'b001,
    FADE_RISE = 3'b010,
    FADE_FALL = 3'b100
  } fade_t;
  typedef logic [5:0] step_t;
endpackage : led_fade_pkg

/* File: verilog/led_channel_fade_dimming_control.sv */
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "led_fade_defs.svh"
// Function
// - trigger ramps channel up in 63 gamma steps
// - trigger while on ramps channel down
// - new trigger reverses an unfinished ramp
// - switch events outrank dimming input
// - internal 220Hz gamma pwm in internal mode
// - internal mode: dimming input acts as trigger
// - external mode: dimming input gates both channels
// - dimming input polarity is selectable
// - momentary switches debounced and latched
// - debounced low pulse toggles the channel
// - level mode: switch level sets channel
// - indicator follows deglitched enable level
// - fault flag low on short or overtemp
// - source select: high external, low internal
// - style select: high pulse, low level
// - polarity select: high active high
// - zero fade time switches instantly
module led_channel_fade_dimming_control #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int PWM_SLOT_CYCLES = `PWM_SLOT_CYCLES,
  parameter logic [`IVL_W-1:0] FADE_STEP_CYCLES = `IVL_W'(`FADE_STEP_CYCLES)
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic main_a_switch_in_i,
  input wire logic main_b_switch_in_i,
  input wire logic indicator_enable_in_i,
  input wire logic dimming_in_i,
  input wire logic dimming_source_select_i,
  input wire logic switch_style_select_i,
  input wire logic dimming_polarity_select_i,
  input wire logic led_short_i,
  input wire logic thermal_shutdown_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  output logic main_a_drive_o,
  output logic main_b_drive_o,
  output logic indicator_drive_o,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe_o
);
  import led_fade_pkg::*;

  function automatic logic [8:0] gamma(input step_t s);
    logic [17:0] sq;
    sq = 18'(s) * 18'(s) * `GAMMA_MUL;
    gamma = (s == `FADE_STEPS) ? 9'h100 : {1'b0, sq[`GAMMA_SHIFT +: 8]};
  endfunction : gamma

  // pin conditioning: three stages, value taken once stages two and three agree
  logic [8:0] pins, s1, s2, s3, stab;
  assign pins = {thermal_shutdown_i, led_short_i, dimming_polarity_select_i, dimming_source_select_i,
                 switch_style_select_i, dimming_in_i, indicator_enable_in_i, main_b_switch_in_i,
                 main_a_switch_in_i};
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1 <= 9'h000;
      s2 <= 9'h000;
      s3 <= 9'h000;
      stab <= 9'h000;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      stab <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & stab);
    end
  end
  logic ind_en, dim_raw, style_pulse, src_ext, pol_high, fault_now;
  assign ind_en = stab[2];
  assign dim_raw = stab[3];
  assign style_pulse = stab[4];
  assign src_ext = stab[5];
  assign pol_high = stab[6];
  assign fault_now = stab[7] | stab[8];

  // main switch debounce, a bounce restarts the window
  logic [1:0] deb, deb_q;
  logic [31:0] deb_cnt [2];
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      deb <= 2'h0;
      deb_q <= 2'h0;
      deb_cnt[0] <= 32'h0;
      deb_cnt[1] <= 32'h0;
    end else begin
      deb_q <= deb;
      for (int c = 0; c < 2; c++) begin
        if (stab[c] == deb[c]) begin
          deb_cnt[c] <= 32'h0;
        end else if (deb_cnt[c] >= 32'(DEBOUNCE_CYCLES - 1)) begin
          deb[c] <= stab[c];
          deb_cnt[c] <= 32'h0;
        end else begin
          deb_cnt[c] <= deb_cnt[c] + 32'h1;
        end
      end
    end
  end
  logic [1:0] sw_fall, sw_rise;
  assign sw_fall = deb_q & ~deb;
  assign sw_rise = ~deb_q & deb;

  // dimming input; edges ignored until the synchroniser has filled,
  // else the zeroed polarity select fakes a trigger after reset
  logic dim_act, dim_act_q, dim_trig;
  logic [2:0] warm;
  assign dim_act = pol_high ? dim_raw : ~dim_raw;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dim_act_q <= 1'b0;
      warm <= 3'h0;
    end else begin
      dim_act_q <= dim_act;
      if (warm != 3'h7) begin
        warm <= warm + 3'h1;
      end
    end
  end
  assign dim_trig = (warm == 3'h7) & ~src_ext & dim_act & ~dim_act_q;

  // requested channel state
  logic [1:0] want;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      want <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (style_pulse) begin
          if (sw_fall[c]) begin
            want[c] <= ~want[c];
          end else if (dim_trig) begin
            want[c] <= ~want[c];
          end
        end else begin
          if (sw_fall[c] | sw_rise[c]) begin
            want[c] <= deb[c];
          end else if (dim_trig) begin
            want[c] <= ~want[c];
          end
        end
      end
    end
  end

  // fade engine; target flips mid ramp simply turn the walk around
  logic [`IVL_W-1:0] fade_up, fade_dn;
  logic [`IVL_W-1:0] ivl_cnt [2];
  step_t step [2];
  step_t step_q [2];
  fade_t fade_st [2];
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < 2; c++) begin
        step[c] <= 6'h00;
        step_q[c] <= 6'h00;
        ivl_cnt[c] <= '0;
        fade_st[c] <= FADE_IDLE;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        step_q[c] <= step[c];
        if (want[c] && step[c] != `FADE_STEPS) begin
          fade_st[c] <= FADE_RISE;
          if (fade_up == '0) begin
            step[c] <= `FADE_STEPS;
            ivl_cnt[c] <= '0;
          end else if (ivl_cnt[c] >= fade_up - 1'b1) begin
            step[c] <= step[c] + 6'h01;
            ivl_cnt[c] <= '0;
          end else begin
            ivl_cnt[c] <= ivl_cnt[c] + 1'b1;
          end
        end else if (!want[c] && step[c] != 6'h00) begin
          fade_st[c] <= FADE_FALL;
          if (fade_dn == '0) begin
            step[c] <= 6'h00;
            ivl_cnt[c] <= '0;
          end else if (ivl_cnt[c] >= fade_dn - 1'b1) begin
            step[c] <= step[c] - 6'h01;
            ivl_cnt[c] <= '0;
          end else begin
            ivl_cnt[c] <= ivl_cnt[c] + 1'b1;
          end
        end else begin
          fade_st[c] <= FADE_IDLE;
          ivl_cnt[c] <= '0;
        end
      end
    end
  end

  // 220Hz pwm: 256 slots per period
  logic [31:0] slot_cnt;
  logic [7:0] phase;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slot_cnt <= 32'h0;
      phase <= 8'h00;
    end else if (slot_cnt >= 32'(PWM_SLOT_CYCLES - 1)) begin
      slot_cnt <= 32'h0;
      phase <= phase + 8'h01;
    end else begin
      slot_cnt <= slot_cnt + 32'h1;
    end
  end

  // outputs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      main_a_drive_o <= 1'b0;
      main_b_drive_o <= 1'b0;
      indicator_drive_o <= 1'b0;
      fault_flag_n_o <= 1'b1;
      fault_flag_n_oe_o <= 1'b0;
    end else begin
      // external gating on top of the fade keeps switch-off authoritative
      main_a_drive_o <= ({1'b0, phase} < gamma(step[0])) & (~src_ext | dim_act);
      main_b_drive_o <= ({1'b0, phase} < gamma(step[1])) & (~src_ext | dim_act);
      indicator_drive_o <= ind_en;
      fault_flag_n_o <= ~fault_now;
      fault_flag_n_oe_o <= fault_now;
    end
  end

  // bus slave, zero wait states
  logic ap, rd_status, dp_wr, fault_q;
  logic [2:0] dp_addr;
  logic [`EV_W-1:0] status, mask, ev;
  assign ap = hsel_i & hready_i & htrans_i[1];
  assign rd_status = ap & ~hwrite_i & (haddr_i[4:2] == `ADDR_STATUS) & (haddr_i[31:5] == 27'h0);
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dp_wr <= 1'b0;
      dp_addr <= 3'h0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      dp_wr <= ap & hwrite_i & (haddr_i[31:5] == 27'h0);
      dp_addr <= haddr_i[4:2];
      if (ap && !hwrite_i) begin
        hrdata_o <= 32'h0;
        if (haddr_i[31:5] == 27'h0) begin
          case (haddr_i[4:2])
            `ADDR_STATUS: hrdata_o <= {29'h0, status};
            `ADDR_MASK: hrdata_o <= {29'h0, mask};
            `ADDR_FADE_UP: hrdata_o <= {8'h00, fade_up};
            `ADDR_FADE_DN: hrdata_o <= {8'h00, fade_dn};
            `ADDR_STATE: hrdata_o <= {8'h00, fault_now, src_ext, style_pulse, pol_high, fade_st[1], fade_st[0],
                                      want, step[1], step[0]};
            default: hrdata_o <= 32'h0;
          endcase
        end
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mask <= `MASK_RESET;
      fade_up <= FADE_STEP_CYCLES;
      fade_dn <= FADE_STEP_CYCLES;
    end else if (dp_wr) begin
      case (dp_addr)
        `ADDR_MASK: mask <= hwdata_i[`EV_W-1:0];
        `ADDR_FADE_UP: fade_up <= hwdata_i[`IVL_W-1:0];
        `ADDR_FADE_DN: fade_dn <= hwdata_i[`IVL_W-1:0];
        default: mask <= mask;
      endcase
    end
  end

  // sticky events, set beats read clear
  assign ev[`EV_DONE_A] = (step[0] != step_q[0]) & ((step[0] == 6'h00) | (step[0] == `FADE_STEPS));
  assign ev[`EV_DONE_B] = (step[1] != step_q[1]) & ((step[1] == 6'h00) | (step[1] == `FADE_STEPS));
  assign ev[`EV_FAULT] = fault_now & ~fault_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status <= 3'h0;
      fault_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      fault_q <= fault_now;
      status <= (rd_status ? 3'h0 : status) | ev;
      irq_o <= |(status & mask);
    end
  end

  property p_ramp_up;
    @(posedge clock_i) disable iff (!rst_n_i)
    (want[0] && step[0] != `FADE_STEPS && fade_up != '0 && $stable(fade_up)) |=>
      (step[0] == $past(step[0]) || step[0] == $past(step[0]) + 6'h01);
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("fade up step wrong");
  property p_ramp_dn;
    @(posedge clock_i) disable iff (!rst_n_i)
    (!want[0] && step[0] != 6'h00 && fade_dn != '0 && $stable(fade_dn)) |=>
      (step[0] == $past(step[0]) || step[0] == $past(step[0]) - 6'h01);
  endproperty
  a_ramp_dn: assert property (p_ramp_dn) else $error("fade down step wrong");
  property p_reverse;
    @(posedge clock_i) disable iff (!rst_n_i)
    (step[0] != 6'h00 && step[0] != `FADE_STEPS && $fell(want[0])) |-> fade_st[0] != FADE_FALL ##1 fade_st[0] == FADE_FALL;
  endproperty
  a_reverse: assert property (p_reverse) else $error("ramp did not reverse");
  property p_instant;
    @(posedge clock_i) disable iff (!rst_n_i)
    (!want[0] && fade_dn == '0 && $stable(want[0])) |=> step[0] == 6'h00;
  endproperty
  a_instant: assert property (p_instant) else $error("instant off missed");
  property p_toggle;
    @(posedge clock_i) disable iff (!rst_n_i)
    (style_pulse && sw_fall[0]) |=> want[0] != $past(want[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pulse did not toggle");
  property p_level;
    @(posedge clock_i) disable iff (!rst_n_i)
    (!style_pulse && (sw_rise[0] || sw_fall[0])) |=> want[0] == $past(deb[0]);
  endproperty
  a_level: assert property (p_level) else $error("level not followed");
  property p_gate;
    @(posedge clock_i) disable iff (!rst_n_i)
    (src_ext && !dim_act) |=> !main_a_drive_o && !main_b_drive_o;
  endproperty
  a_gate: assert property (p_gate) else $error("external gate ignored");
  property p_fault;
    @(posedge clock_i) disable iff (!rst_n_i)
    fault_now |=> (!fault_flag_n_o && fault_flag_n_oe_o);
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag not low");
  property p_ind;
    @(posedge clock_i) disable iff (!rst_n_i)
    ##1 indicator_drive_o == $past(ind_en);
  endproperty
  a_ind: assert property (p_ind) else $error("indicator mismatch");
  c_full: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(step[0] == `FADE_STEPS));
  c_rev: cover property (@(posedge clock_i) disable iff (!rst_n_i) fade_st[0] == FADE_RISE ##1 fade_st[0] == FADE_FALL);
  c_irq: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule : led_channel_fade_dimming_control

/* File: verification/switch_source_model.sv */
`timescale 1ns/10ps
module switch_source_model #(
  parameter int PULSE_CYCLES = 12
) (
  input wire logic clock_i,
  input wire logic pulse_style_i,
  input wire logic active_high_i,
  input wire logic a_req_i,
  input wire logic b_req_i,
  input wire logic dim_req_i,
  output logic a_pin_o,
  output logic b_pin_o,
  output logic dim_pin_o
);
  logic a_last = 1'b0;
  logic b_last = 1'b0;
  int a_cnt = 0;
  int b_cnt = 0;
  // each change of a request is one press, held low well past the debounce window
  always @(posedge clock_i) begin
    a_last <= a_req_i;
    b_last <= b_req_i;
    a_cnt <= (a_req_i != a_last) ? PULSE_CYCLES : ((a_cnt > 0) ? a_cnt - 1 : 0);
    b_cnt <= (b_req_i != b_last) ? PULSE_CYCLES : ((b_cnt > 0) ? b_cnt - 1 : 0);
  end
  // pulled-up pin idles high in pulse style; a latched switch shows its level
  assign a_pin_o = pulse_style_i ? (a_cnt == 0) : a_req_i;
  assign b_pin_o = pulse_style_i ? (b_cnt == 0) : b_req_i;
  // an active-low source idles high
  assign dim_pin_o = active_high_i ? dim_req_i : ~dim_req_i;
endmodule : switch_source_model

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clock_i;
  logic rst_n_i;
  logic a_req, b_req, dim_req, a_pin, b_pin, dim_pin;
  logic ind_en, src_sel, style_sel, pol_sel, short_in, therm_in;
  logic hsel, hwrite, hready, hresp, irq;
  logic drive_a, drive_b, drive_ind, fault_n, fault_oe;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int n_mismatch, checks_done;

  switch_source_model src_u (.clock_i(clock_i), .pulse_style_i(style_sel), .active_high_i(pol_sel),
    .a_req_i(a_req), .b_req_i(b_req), .dim_req_i(dim_req), .a_pin_o(a_pin), .b_pin_o(b_pin), .dim_pin_o(dim_pin));

  // short counts keep the ramps to a few hundred cycles
  led_channel_fade_dimming_control #(.DEBOUNCE_CYCLES(4), .PWM_SLOT_CYCLES(2), .FADE_STEP_CYCLES(24'h3)) dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .main_a_switch_in_i(a_pin), .main_b_switch_in_i(b_pin),
    .indicator_enable_in_i(ind_en), .dimming_in_i(dim_pin), .dimming_source_select_i(src_sel),
    .switch_style_select_i(style_sel), .dimming_polarity_select_i(pol_sel), .led_short_i(short_in),
    .thermal_shutdown_i(therm_in), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .irq_o(irq), .main_a_drive_o(drive_a), .main_b_drive_o(drive_b),
    .indicator_drive_o(drive_ind), .fault_flag_n_o(fault_n), .fault_flag_n_oe_o(fault_oe));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(posedge clock_i);
  endtask : ticks

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_ready

  // single word transfer; hrdata is taken at the edge that ends the data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb

  // polls the state word until a step field reaches v, within lim reads
  task automatic wait_step(input int sh, input logic [5:0] v, input int lim);
    int n;
    n = 0;
    do begin
      ahb(1'b0, 32'h10, 32'h0);
      n++;
    end while (rd[sh +: 6] !== v && n < lim);
    chk(rd[sh +: 6], v);
    if (rd[sh +: 6] !== v) begin
      complete_run();
    end
  endtask : wait_step

  task automatic hold(input logic ea, input logic eb);
    repeat (16) begin
      @(posedge clock_i);
      chk({drive_a, drive_b}, {ea, eb});
    end
  endtask : hold

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst_n_i = 1'b0;
    {a_req, b_req, dim_req, ind_en, src_sel, short_in, therm_in} = 7'h00;
    style_sel = 1'b1;
    pol_sel = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
    ticks(20);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk({drive_a, drive_b, drive_ind, fault_n, fault_oe, irq}, 6'b000100);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd[19:0], 20'h24000);
    ahb(1'b0, 32'h04, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h14, 32'hFFFFFFFF);
    ahb(1'b0, 32'h14, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h04, 32'h7);
    ahb(1'b1, 32'h08, 32'h3);
    ahb(1'b1, 32'h0C, 32'h3);
    a_req <= 1'b1;
    wait_step(0, 6'd10, 400);
    chk(rd[16:14], 3'b010);
    wait_step(0, 6'd63, 400);
    // irq lags the last step by two edges; let it settle before looking
    ticks(2);
    chk(irq, 1'b1);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd[0], 1'b1);
    hold(1'b1, 1'b0);
    a_req <= 1'b0;
    wait_step(0, 6'd40, 400);
    chk(rd[16:14], 3'b100);
    a_req <= 1'b1;
    wait_step(0, 6'd50, 400);
    chk(rd[16:14], 3'b010);
    a_req <= 1'b0;
    wait_step(0, 6'd0, 400);
    hold(1'b0, 1'b0);
    ahb(1'b0, 32'h00, 32'h0);
    ahb(1'b1, 32'h08, 32'h0);
    ahb(1'b1, 32'h0C, 32'h0);
    b_req <= 1'b1;
    wait_step(6, 6'd63, 20);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd[2:0], 3'h2);
    b_req <= 1'b0;
    wait_step(6, 6'd0, 20);
    // level follow: latched switch state decides the channel
    style_sel <= 1'b0;
    ticks(24);
    b_req <= 1'b1;
    wait_step(6, 6'd63, 20);
    b_req <= 1'b0;
    wait_step(6, 6'd0, 20);
    dim_req <= 1'b1;
    wait_step(0, 6'd63, 20);
    chk(rd[11:0], 12'hFFF);
    dim_req <= 1'b0;
    ticks(12);
    pol_sel <= 1'b0;
    ticks(12);
    dim_req <= 1'b1;
    wait_step(0, 6'd0, 20);
    chk(rd[11:0], 12'h000);
    src_sel <= 1'b1;
    ticks(12);
    pol_sel <= 1'b1;
    a_req <= 1'b1;
    wait_step(0, 6'd63, 20);
    dim_req <= 1'b0;
    ticks(12);
    hold(1'b0, 1'b0);
    dim_req <= 1'b1;
    ticks(12);
    hold(1'b1, 1'b0);
    ind_en <= 1'b1;
    ticks(12);
    chk(drive_ind, 1'b1);
    ind_en <= 1'b0;
    ticks(12);
    chk(drive_ind, 1'b0);
    short_in <= 1'b1;
    ticks(12);
    chk({fault_n, fault_oe, irq}, 3'b011);
    short_in <= 1'b0;
    ticks(12);
    chk({fault_n, fault_oe}, 2'b10);
    ahb(1'b0, 32'h00, 32'h0);
    ahb(1'b1, 32'h04, 32'h0);
    therm_in <= 1'b1;
    ticks(12);
    chk({fault_n, fault_oe, irq}, 3'b010);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd[2], 1'b1);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd[2], 1'b0);
    therm_in <= 1'b0;
    ticks(12);
    chk({fault_n, fault_oe}, 2'b10);
    complete_run();
  end
endmodule : testbench
